// ### hw/plev_defs.svh
// constants of the program lock, encryption and verify block
`ifndef PLEV_DEFS_SVH
`define PLEV_DEFS_SVH
////////////////////////////////////////////////////////////////////////////////
// array geometry
`define PLEV_CODE_AW 14
`define PLEV_ENC_AW 6
`define PLEV_DW 8
`define PLEV_ERASED 8'hFF
`define PLEV_ERASE_LAST 14'h3FFF
`define PLEV_LOCK_ERASED 3'h7
////////////////////////////////////////////////////////////////////////////////
// register map, byte addresses
`define PLEV_REG_CTRL 4'h0
`define PLEV_REG_STATUS 4'h4
`define PLEV_REG_PULSES 4'h8
`define PLEV_CTRL_MASK_BIT 0
`define PLEV_CTRL_ERASE_BIT 1
`define PLEV_STAT_REFUSED_BIT 5
`define PLEV_CTRL_RST 1'h0
////////////////////////////////////////////////////////////////////////////////
// control pin patterns {p2.6, p2.7, p3.3, p3.6, p3.7}
`define PLEV_SEL_PROGRAM_PULSE_CODE 5'h0F
`define PLEV_SEL_PROGRAM_PULSE_ENC 5'h0D
`define PLEV_SEL_LOCK1 5'h1F
`define PLEV_SEL_LOCK2 5'h1C
`define PLEV_SEL_LOCK3 5'h16
`define PLEV_SEL_VERIFY 5'h03
`define PLEV_SEL_SIG 5'h00
////////////////////////////////////////////////////////////////////////////////
// identification bytes; the values are arbitrary
`define PLEV_SIG_ADDR0 14'h0030
`define PLEV_SIG_ADDR1 14'h0031
`define PLEV_SIG_ADDR2 14'h0060
`define PLEV_SIG_VAL0 8'hA1
`define PLEV_SIG_VAL1 8'hA2
`define PLEV_SIG_VAL2 8'hA3
////////////////////////////////////////////////////////////////////////////////
// timing
`define PLEV_SYS_CLK_HZ 25000000
`define PLEV_OSC_MIN_HZ 4000000
`define PLEV_VERIFY_OSC_PERIODS 48
`define PLEV_VERIFY_MAX_CYC ((`PLEV_VERIFY_OSC_PERIODS * `PLEV_SYS_CLK_HZ) / `PLEV_OSC_MIN_HZ)
`endif

// ### hw/plev_pkg.sv
// types of the program lock, encryption and verify block
package plev_pkg;
  // programmer control pins
  typedef struct packed {
    logic ctl_p26;
    logic ctl_p27;
    logic ctl_p33;
    logic ctl_p36;
    logic ctl_p37;
  } plev_ctl_t;
  // restrictions handed to the cpu core
  typedef struct packed {
    logic code_table_read_block;
    logic strap_latch;
    logic program_inhibit;
    logic verify_inhibit;
    logic external_exec_inhibit;
  } plev_inhibit_t;
  typedef enum logic [2:0] {
    mode_idle, mode_program_pulse_code, mode_program_pulse_enc, mode_lock1,
    mode_lock2, mode_lock3, mode_verify, mode_sig
  } plev_mode_t;
  typedef enum logic [1:0] {st_idle, st_read, st_write, st_erase} plev_state_t;
endpackage

// ### hw/plev_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module plev_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule

// ### hw/plev_mem.sv
// single-port byte memory with registered read data
`timescale 1ns/1ps
module plev_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // cells carry no reset: they model non-volatile storage
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  // read data always from a register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= mem[addr];
    end
  end
endmodule

// ### hw/plev_top.sv
// program lock, encryption array, signature and verify logic of the code store
// Behaviour
// - 64-byte encryption array, erased to ones
// - verify outputs code XNOR encryption byte
// - erase clears encryption array and lock bits
// - no locks: features off, XNOR stays
// - level two: block tables, latch strap, no programming
// - level three adds verify disable
// - level four adds external execution disable
// - undefined lock combinations get all restrictions
// - mask variant: one lock, encryption needs it
// - signature read returns three fixed bytes
// - erased cells read as one
// - verify data valid within 48 periods
// - lock bits have no read-back path
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "plev_defs.svh"
module plev_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // programmer pins
  input wire logic [`PLEV_CODE_AW-1:0] pin_address,
  input wire logic [`PLEV_DW-1:0] pin_data_in,
  output logic [`PLEV_DW-1:0] pin_data_out,
  output logic pin_data_oe,
  input wire plev_pkg::plev_ctl_t pin_ctl,
  input wire logic pin_program_pulse_mode,
  input wire logic pin_psen_n,
  input wire logic latch_enable_program_pulse_n,
  input wire logic pin_vpp_high,
  input wire logic external_access_strap,
  // cpu core side
  output plev_pkg::plev_inhibit_t core_inhibit,
  output logic core_ea
);
  localparam int VERIFY_MAX = `PLEV_VERIFY_MAX_CYC;

  logic [`PLEV_CODE_AW-1:0] s_addr;
  logic [`PLEV_DW-1:0] s_data;
  plev_pkg::plev_ctl_t s_ctl;
  logic s_program_pulse, s_psen_n, s_pulse_n, s_vpp, s_ea;
  logic pulse_prev_q;
  logic pulse_fall;
  plev_pkg::plev_mode_t mode, mode_d1_q;
  plev_pkg::plev_state_t state_q;
  logic [2:0] lock_q;
  logic mask_q, erase_req_q, refused_q;
  logic [`PLEV_CODE_AW-1:0] erase_cnt_q, program_pulse_addr_q, addr_d1_q;
  logic [`PLEV_DW-1:0] program_pulse_data_q;
  logic tgt_code_q;
  logic [7:0] pulse_cnt_q;
  logic enc_active;
  plev_pkg::plev_inhibit_t inhibit_q;
  logic ea_q;
  logic [1:0] rel_cnt_q;
  logic [`PLEV_DW-1:0] dout_q;
  logic oe_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic code_we, enc_we;
  logic [`PLEV_CODE_AW-1:0] code_addr;
  logic [`PLEV_ENC_AW-1:0] enc_addr;
  logic [`PLEV_DW-1:0] code_wd, enc_wd, code_rdata, enc_rdata;
  logic bus_req, bus_wr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every programmer pin is asynchronous to sys_clk
  plev_sync #(
    .W(32)
  ) u_sync (
    .clk(sys_clk),
    .rst(rst),
    .d({pin_address, pin_data_in, pin_ctl, pin_program_pulse_mode, pin_psen_n,
        latch_enable_program_pulse_n, pin_vpp_high, external_access_strap}),
    .q({s_addr, s_data, s_ctl, s_program_pulse, s_psen_n, s_pulse_n, s_vpp, s_ea})
  );

  // falling edge of the program pulse, seen after synchronisation
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pulse_prev_q <= 1'h0; // follows the synchroniser's reset level: no false edge after reset
    else
      pulse_prev_q <= s_pulse_n;
  end
  assign pulse_fall = pulse_prev_q & ~s_pulse_n;

  //////////////////////////////////////////////////////////////////////////////
  // mode decode from the control pins; programming needs vpp, reads forbid it
  function automatic plev_pkg::plev_mode_t plev_decode_mode(
    input plev_pkg::plev_ctl_t ctl, input logic program_pulse, input logic psen_n,
    input logic vpp);
    plev_pkg::plev_mode_t m;
    m = plev_pkg::mode_idle;
    if (program_pulse && !psen_n)
    begin
      unique case (ctl)
        `PLEV_SEL_PROGRAM_PULSE_CODE: m = vpp ? plev_pkg::mode_program_pulse_code : plev_pkg::mode_idle;
        `PLEV_SEL_PROGRAM_PULSE_ENC: m = vpp ? plev_pkg::mode_program_pulse_enc : plev_pkg::mode_idle;
        `PLEV_SEL_LOCK1: m = vpp ? plev_pkg::mode_lock1 : plev_pkg::mode_idle;
        `PLEV_SEL_LOCK2: m = vpp ? plev_pkg::mode_lock2 : plev_pkg::mode_idle;
        `PLEV_SEL_LOCK3: m = vpp ? plev_pkg::mode_lock3 : plev_pkg::mode_idle;
        `PLEV_SEL_VERIFY: m = vpp ? plev_pkg::mode_idle : plev_pkg::mode_verify;
        `PLEV_SEL_SIG: m = vpp ? plev_pkg::mode_idle : plev_pkg::mode_sig;
        default: m = plev_pkg::mode_idle;
      endcase
    end
    return m;
  endfunction
  assign mode = plev_decode_mode(s_ctl, s_program_pulse, s_psen_n, s_vpp);

  //////////////////////////////////////////////////////////////////////////////
  // lock level decode into the restriction set
  function automatic plev_pkg::plev_inhibit_t plev_decode_lock(
    input logic [2:0] lock, input logic mask);
    plev_pkg::plev_inhibit_t r;
    logic lv2, lv3, lv4;
    lv2 = 1'h0;
    lv3 = 1'h0;
    lv4 = 1'h0;
    if (mask)
      lv2 = ~lock[0];
    else
    begin
      unique case (lock)
        3'h7: lv2 = 1'h0;
        3'h6: lv2 = 1'h1;
        3'h4:
        begin
          lv2 = 1'h1;
          lv3 = 1'h1;
        end
        default:
        begin
          // for all three programmed; the safe choice for the rest
          lv2 = 1'h1;
          lv3 = 1'h1;
          lv4 = 1'h1;
        end
      endcase
    end
    r.code_table_read_block = lv2;
    r.strap_latch = lv2;
    r.program_inhibit = lv2;
    r.verify_inhibit = lv3;
    r.external_exec_inhibit = lv4;
    return r;
  endfunction

  // restrictions registered so the core sees glitch-free levels
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      inhibit_q <= '0;
    else
      inhibit_q <= plev_decode_lock(lock_q, mask_q);
  end

  // encryption in the mask variant only works together with its lock bit
  assign enc_active = mask_q ? ~lock_q[0] : 1'h1;

  //////////////////////////////////////////////////////////////////////////////
  // strap capture: sync needs two edges after release before it is valid
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rel_cnt_q <= 2'h0;
      ea_q <= 1'h0;
    end
    else
    begin
      if (rel_cnt_q != 2'h3)
        rel_cnt_q <= rel_cnt_q + 2'h1;
      if (rel_cnt_q == 2'h2 || !inhibit_q.strap_latch)
        ea_q <= s_ea;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lock cells; reset models a virgin part, erase returns them to ones
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      lock_q <= `PLEV_LOCK_ERASED;
    else if (state_q == plev_pkg::st_idle && erase_req_q)
      lock_q <= `PLEV_LOCK_ERASED;
    else if (state_q == plev_pkg::st_idle && pulse_fall)
    begin
      // lock bits stay programmable so a part can be raised to a higher level
      unique case (mode)
        plev_pkg::mode_lock1: lock_q[0] <= 1'h0;
        plev_pkg::mode_lock2: lock_q[1] <= mask_q ? lock_q[1] : 1'h0;
        plev_pkg::mode_lock3: lock_q[2] <= mask_q ? lock_q[2] : 1'h0;
        default: lock_q <= lock_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // program and erase sequencer; a pulse only clears bits, like an eprom cell
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= plev_pkg::st_idle;
      erase_cnt_q <= '0;
      program_pulse_addr_q <= '0;
      program_pulse_data_q <= '0;
      tgt_code_q <= 1'h0;
    end
    else
    begin
      unique case (state_q)
        plev_pkg::st_idle:
        begin
          if (erase_req_q)
          begin
            state_q <= plev_pkg::st_erase;
            erase_cnt_q <= '0;
          end
          else if (pulse_fall && !inhibit_q.program_inhibit &&
                   (mode == plev_pkg::mode_program_pulse_code || mode == plev_pkg::mode_program_pulse_enc))
          begin
            state_q <= plev_pkg::st_read;
            program_pulse_addr_q <= s_addr;
            program_pulse_data_q <= s_data;
            tgt_code_q <= (mode == plev_pkg::mode_program_pulse_code);
          end
        end
        plev_pkg::st_read: state_q <= plev_pkg::st_write;
        plev_pkg::st_write: state_q <= plev_pkg::st_idle;
        plev_pkg::st_erase:
        begin
          erase_cnt_q <= erase_cnt_q + 14'h0001;
          if (erase_cnt_q == `PLEV_ERASE_LAST)
            state_q <= plev_pkg::st_idle;
        end
      endcase
    end
  end

  // memory port steering: erase, read-modify-write, else live verify address
  always_comb
  begin
    code_addr = s_addr;
    enc_addr = s_addr[`PLEV_ENC_AW-1:0];
    code_we = 1'h0;
    enc_we = 1'h0;
    code_wd = program_pulse_data_q & code_rdata;
    enc_wd = program_pulse_data_q & enc_rdata;
    unique case (state_q)
      plev_pkg::st_erase:
      begin
        code_addr = erase_cnt_q;
        enc_addr = erase_cnt_q[`PLEV_ENC_AW-1:0];
        code_we = 1'h1;
        enc_we = (erase_cnt_q[`PLEV_CODE_AW-1:`PLEV_ENC_AW] == 8'h00);
        code_wd = `PLEV_ERASED;
        enc_wd = `PLEV_ERASED;
      end
      plev_pkg::st_read:
      begin
        code_addr = program_pulse_addr_q;
        enc_addr = program_pulse_addr_q[`PLEV_ENC_AW-1:0];
      end
      plev_pkg::st_write:
      begin
        code_addr = program_pulse_addr_q;
        enc_addr = program_pulse_addr_q[`PLEV_ENC_AW-1:0];
        code_we = tgt_code_q;
        enc_we = ~tgt_code_q;
      end
      plev_pkg::st_idle: code_we = 1'h0;
    endcase
  end

  plev_mem #(
    .AW(`PLEV_CODE_AW),
    .DW(`PLEV_DW)
  ) u_code (
    .clk(sys_clk),
    .rst(rst),
    .we(code_we),
    .addr(code_addr),
    .wdata(code_wd),
    .rdata_q(code_rdata)
  );

  plev_mem #(
    .AW(`PLEV_ENC_AW),
    .DW(`PLEV_DW)
  ) u_enc (
    .clk(sys_clk),
    .rst(rst),
    .we(enc_we),
    .addr(enc_addr),
    .wdata(enc_wd),
    .rdata_q(enc_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // verify pipeline: stage one follows the memory read, stage two drives pins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_d1_q <= plev_pkg::mode_idle;
      addr_d1_q <= '0;
    end
    else
    begin
      mode_d1_q <= (state_q == plev_pkg::st_idle) ? mode : plev_pkg::mode_idle;
      addr_d1_q <= s_addr;
    end
  end

  // output byte; a disabled verify shows ones, hiding the array content
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dout_q <= `PLEV_ERASED;
      oe_q <= 1'h0;
    end
    else
    begin
      oe_q <= (mode_d1_q == plev_pkg::mode_verify || mode_d1_q == plev_pkg::mode_sig);
      if (mode_d1_q == plev_pkg::mode_sig)
      begin
        unique case (addr_d1_q)
          `PLEV_SIG_ADDR0: dout_q <= `PLEV_SIG_VAL0;
          `PLEV_SIG_ADDR1: dout_q <= `PLEV_SIG_VAL1;
          `PLEV_SIG_ADDR2: dout_q <= `PLEV_SIG_VAL2;
          default: dout_q <= `PLEV_ERASED;
        endcase
      end
      else if (inhibit_q.verify_inhibit)
        dout_q <= `PLEV_ERASED;
      else if (enc_active)
        dout_q <= ~(code_rdata ^ enc_rdata);
      else
        dout_q <= code_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pulse counter lets software watch 5 or 25 pulses go by; a pulse in the clearing cycle counts as one
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pulse_cnt_q <= 8'h00;
    else if (pulse_fall && mode != plev_pkg::mode_idle)
      pulse_cnt_q <= (bus_wr && avs_address == `PLEV_REG_PULSES) ?
                     8'h01 : pulse_cnt_q + 8'h01;
    else if (bus_wr && avs_address == `PLEV_REG_PULSES)
      pulse_cnt_q <= 8'h00;
  end

  // refused-program flag: sticky, write one to clear, set wins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      refused_q <= 1'h0;
    else if (pulse_fall && inhibit_q.program_inhibit &&
             (mode == plev_pkg::mode_program_pulse_code || mode == plev_pkg::mode_program_pulse_enc))
      refused_q <= 1'h1;
    else if (bus_wr && avs_address == `PLEV_REG_STATUS &&
             avs_writedata[`PLEV_STAT_REFUSED_BIT])
      refused_q <= 1'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on the second edge of a request
  assign bus_req = (avs_read | avs_write) & wait_q;
  // writes land only at the edge that sees waitrequest low
  assign bus_wr = avs_write & ~wait_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wait_q <= 1'h1;
      rdata_q <= 32'h0000_0000;
      mask_q <= `PLEV_CTRL_RST;
      erase_req_q <= 1'h0;
    end
    else
    begin
      wait_q <= ~bus_req;
      if (state_q == plev_pkg::st_idle)
        erase_req_q <= 1'h0;
      if (bus_wr && avs_address == `PLEV_REG_CTRL)
      begin
        mask_q <= avs_writedata[`PLEV_CTRL_MASK_BIT];
        erase_req_q <= avs_writedata[`PLEV_CTRL_ERASE_BIT];
      end
      if (bus_req && avs_read)
      begin
        // lock bits themselves are never readable here
        unique case (avs_address)
          `PLEV_REG_CTRL: rdata_q <= {31'h0, mask_q};
          `PLEV_REG_STATUS: rdata_q <= {26'h0, refused_q, mode, erase_req_q,
                                        state_q == plev_pkg::st_erase};
          `PLEV_REG_PULSES: rdata_q <= {24'h0, pulse_cnt_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign pin_data_out = dout_q;
  assign pin_data_oe = oe_q;
  assign core_inhibit = inhibit_q;
  assign core_ea = ea_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_enc_erase;
    (state_q == plev_pkg::st_erase && erase_cnt_q < 14'h0040) |-> enc_we && enc_wd == 8'hFF;
  endproperty
  a_enc_erase: assert property (p_enc_erase) else $error("enc array not erased");

  property p_xnor;
    (mode_d1_q == plev_pkg::mode_verify && !inhibit_q.verify_inhibit && enc_active)
      |=> dout_q == ~($past(code_rdata) ^ $past(enc_rdata));
  endproperty
  a_xnor: assert property (p_xnor) else $error("verify byte not xnor");

  property p_erase_locks;
    $fell(state_q == plev_pkg::st_erase) |-> lock_q == 3'h7;
  endproperty
  a_erase_locks: assert property (p_erase_locks) else $error("locks left after erase");

  property p_no_program_pulse;
    (state_q == plev_pkg::st_idle && pulse_fall && !erase_req_q &&
     inhibit_q.program_inhibit) |=> state_q == plev_pkg::st_idle;
  endproperty
  a_no_program_pulse: assert property (p_no_program_pulse) else $error("locked part programmed");

  property p_verify_off;
    (mode_d1_q == plev_pkg::mode_verify && inhibit_q.verify_inhibit) |=> dout_q == 8'hFF;
  endproperty
  a_verify_off: assert property (p_verify_off) else $error("verify not disabled");

  property p_ext_off;
    (lock_q == 3'h0 && !mask_q) [*2] |-> core_inhibit.external_exec_inhibit;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("ext exec not disabled");

  property p_mask;
    (mask_q && lock_q[0] && mode_d1_q == plev_pkg::mode_verify)
      |=> ($past(inhibit_q.verify_inhibit) ? dout_q == 8'hFF : dout_q == $past(code_rdata));
  endproperty
  a_mask: assert property (p_mask) else $error("mask variant encrypts");

  property p_sig;
    (mode_d1_q == plev_pkg::mode_sig && addr_d1_q == 14'h0031) |=> dout_q == 8'hA2 && oe_q;
  endproperty
  a_sig: assert property (p_sig) else $error("signature byte wrong");

  property p_erase_ones;
    (state_q == plev_pkg::st_erase) |-> code_we && code_wd == 8'hFF;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erase wrote non-ones");

  property p_verify_time;
    (mode == plev_pkg::mode_verify && state_q == plev_pkg::st_idle)
      |-> ##[1:VERIFY_MAX] oe_q;
  endproperty
  a_verify_time: assert property (p_verify_time) else $error("verify data late");
endmodule

// ### dv/plev_pgm.sv
// programmer model that drives the code store pins
`timescale 1ns/1ps
module plev_pgm (
  // clock
  input wire logic sys_clk,
  // pins toward the device
  output logic [13:0] pin_address,
  output logic [7:0] pin_data_in,
  output plev_pkg::plev_ctl_t pin_ctl,
  output logic pin_program_pulse_mode,
  output logic pin_psen_n,
  output logic latch_enable_program_pulse_n,
  output logic pin_vpp_high,
  // byte driven back by the device
  input wire logic [7:0] pin_data_out
);
  // idle levels; psen high keeps every mode off
  initial
  begin
    pin_address = 14'h0000;
    pin_data_in = 8'h00;
    pin_ctl = 5'h1E;
    pin_program_pulse_mode = 1'b1;
    pin_psen_n = 1'b1;
    latch_enable_program_pulse_n = 1'b1;
    pin_vpp_high = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // setup and hold are scaled down but stay well past the synchroniser depth
  task automatic program_pulse(input logic [4:0] sel, input logic [13:0] a, input logic [7:0] dt,
    input int n);
    @(posedge sys_clk);
    pin_ctl <= sel;
    pin_address <= a;
    pin_data_in <= dt;
    pin_psen_n <= 1'b0;
    pin_vpp_high <= 1'b1;
    repeat (8) @(posedge sys_clk);
    repeat (n)
    begin
      latch_enable_program_pulse_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      latch_enable_program_pulse_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    pin_vpp_high <= 1'b0;
    pin_psen_n <= 1'b1;
    pin_data_in <= ~dt; // released lines do not keep the last value
  endtask
  // read one byte; sampled at the falling edge where it has settled
  task automatic vfy(input logic [4:0] sel, input logic [13:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    pin_ctl <= sel;
    pin_address <= a;
    pin_psen_n <= 1'b0;
    pin_data_in <= ~pin_data_in;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    q = pin_data_out;
    @(posedge sys_clk);
    pin_psen_n <= 1'b1;
  endtask
endmodule

// ### dv/plev_top_bench.sv
// self-checking bench of the program lock, encryption and verify block
`timescale 1ns/1ps
`include "plev_defs.svh"
module plev_top_bench;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, pin_data_oe, core_ea;
  logic pin_program_pulse_mode, pin_psen_n, latch_enable_program_pulse_n, pin_vpp_high;
  logic external_access_strap;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [13:0] pin_address, a;
  logic [7:0] pin_data_in, pin_data_out, c, e, d;
  plev_pkg::plev_ctl_t pin_ctl;
  plev_pkg::plev_inhibit_t core_inhibit;
  int bad_count, n_compared, cyc;
  logic [13:0] sa [4] = '{14'h0030, 14'h0031, 14'h0060, 14'h0032};
  logic [7:0] sv [4] = '{`PLEV_SIG_VAL0, `PLEV_SIG_VAL1, `PLEV_SIG_VAL2, 8'hFF};
  logic [4:0] lk [3] = '{`PLEV_SEL_LOCK1, `PLEV_SEL_LOCK2, `PLEV_SEL_LOCK3};
  logic [4:0] inh [3] = '{5'h1C, 5'h1E, 5'h1F};
  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  plev_top plev_top_i (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_address(pin_address), .pin_data_in(pin_data_in), .pin_data_out(pin_data_out),
    .pin_data_oe(pin_data_oe), .pin_ctl(pin_ctl), .pin_program_pulse_mode(pin_program_pulse_mode),
    .pin_psen_n(pin_psen_n), .latch_enable_program_pulse_n(latch_enable_program_pulse_n),
    .pin_vpp_high(pin_vpp_high), .external_access_strap(external_access_strap),
    .core_inhibit(core_inhibit), .core_ea(core_ea));
  plev_pgm plev_pgm_i (.sys_clk(sys_clk), .pin_address(pin_address),
    .pin_data_in(pin_data_in), .pin_ctl(pin_ctl), .pin_program_pulse_mode(pin_program_pulse_mode),
    .pin_psen_n(pin_psen_n), .latch_enable_program_pulse_n(latch_enable_program_pulse_n),
    .pin_vpp_high(pin_vpp_high), .pin_data_out(pin_data_out));
  //////////////////////////////////////////////////////////////////////////////
  // closing report
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one compare
  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    n_compared++;
    if (got !== ex)
    begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, ex);
    end
  endtask
  // expected verify byte
  function automatic logic [7:0] xn(input logic [7:0] code, input logic [7:0] key);
    return ~(code ^ key);
  endfunction
  // one verify read and compare
  task automatic ver(input logic [13:0] ad, input logic [7:0] ex);
    plev_pgm_i.vfy(`PLEV_SEL_VERIFY, ad, d);
    chk(32'(d), 32'(ex));
    chk(32'(pin_data_oe), 32'h1);
  endtask
  // waitrequest is sampled at the rising edge; read data are taken and the
  // request released at the edge that sees it low
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // start an erase and poll until neither busy nor pending
  task automatic erase;
    bus(1'b1, `PLEV_REG_CTRL, 32'h2);
    q = 32'h1;
    while (q[1:0] !== 2'h0)
      bus(1'b0, `PLEV_REG_STATUS, 32'h0);
  endtask
  // hang guard; two erases fit well inside
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(93268));
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    external_access_strap = 1'($urandom);
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    erase();
    chk(32'(core_inhibit), 32'h0);
    chk(32'(core_ea), 32'(external_access_strap));
    repeat (3) ver(14'($urandom), 8'hFF);
    bus(1'b1, `PLEV_REG_PULSES, 32'h0);
    a = 14'($urandom);
    c = 8'($urandom);
    e = 8'($urandom) & 8'hFE;
    plev_pgm_i.program_pulse(`PLEV_SEL_PROGRAM_PULSE_CODE, a, c, 5);
    bus(1'b0, `PLEV_REG_PULSES, 32'h0);
    chk(q, 32'h5);
    ver(a, c);
    plev_pgm_i.program_pulse(`PLEV_SEL_PROGRAM_PULSE_ENC, a, e, 25);
    ver(a, xn(c, e));
    a = a ^ 14'h0040; // unprogrammed cell sharing the key byte exposes it
    ver(a, e);
    for (int i = 0; i < 4; i++)
    begin
      plev_pgm_i.vfy(`PLEV_SEL_SIG, sa[i], d);
      chk(32'(d), 32'(sv[i]));
    end
    for (int i = 0; i < 3; i++)
    begin
      plev_pgm_i.program_pulse(lk[i], 14'h0000, 8'h00, 25);
      repeat (4) @(posedge sys_clk);
      chk(32'(core_inhibit), 32'(inh[i]));
      if (i == 0)
      begin
        plev_pgm_i.program_pulse(`PLEV_SEL_PROGRAM_PULSE_CODE, a, 8'h00, 5);
        bus(1'b0, `PLEV_REG_STATUS, 32'h0);
        chk(32'(q[5]), 32'h1);
        // a locked part keeps the strap level it had when the lock took hold
        external_access_strap <= !external_access_strap;
        repeat (6) @(posedge sys_clk);
        chk(32'(core_ea), 32'(!external_access_strap));
      end
      ver(a, i == 0 ? e : 8'hFF);
    end
    erase();
    chk(32'(core_inhibit), 32'h0);
    chk(32'(core_ea), 32'(external_access_strap));
    ver(a, 8'hFF);
    bus(1'b1, `PLEV_REG_CTRL, 32'h1);
    plev_pgm_i.program_pulse(`PLEV_SEL_PROGRAM_PULSE_ENC, a, e, 25);
    ver(a, 8'hFF);
    plev_pgm_i.program_pulse(`PLEV_SEL_LOCK1, 14'h0000, 8'h00, 25);
    ver(a, e);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    wrap_up();
  end
endmodule
